// ==== fies_params.svh ====
`ifndef FIES_PARAMS_SVH
`define FIES_PARAMS_SVH

// Register indices; printed offsets are not all multiples of four
`define FIES_IDX_ENABLES 8'h0c
`define FIES_IDX_SUPPLY 8'h0e
// Event status, clear and enable registers
`define FIES_IDX_EVT_STATUS 8'h20
`define FIES_IDX_EVT_CLEAR 8'h21
`define FIES_IDX_EVT_ENABLE 8'h22

// Enable register fields (low bit of each 2-bit field)
`define FIES_EN_GLOBAL_LO 6
`define FIES_EN_TIMEOUT_LO 4
`define FIES_EN_STRING_LO 2
`define FIES_EN_LED_LO 0
`define FIES_ENABLES_RESET 16'h00aa

// Supply register reset value
`define FIES_SUPPLY_RESET 16'h0000

// Enable field codes
`define FIES_CODE_DIS 2'h1
`define FIES_CODE_EN 2'h3
`define FIES_READ_EN 2'h2
`define FIES_READ_DIS 2'h0

// Number of supply faults and of event bits (three LED-side sources plus the supply summary)
`define FIES_N_SUPPLY 8
`define FIES_N_EVT 4

`endif

// ==== fies_pkg.sv ====
package fies_pkg;

   typedef enum logic [2:0] {
      FIES_W_IDLE = 3'b001,
      FIES_W_RESP = 3'b010,
      FIES_W_HOLD = 3'b100
   } fies_wstate_t;

   typedef enum logic [1:0] {
      FIES_R_IDLE = 2'b01,
      FIES_R_DATA = 2'b10
   } fies_rstate_t;

   // Decoded write to one of our registers
   typedef struct packed {
      logic valid;
      logic [7:0] index;
      logic [15:0] data;
      logic [1:0] lanes;
   } fies_wr_t;

endpackage : fies_pkg

// ==== fies_enable_field.sv ====
`timescale 1ns/1ps
`include "fies_params.svh"

// One 2-bit interrupt enable field with protected write codes
module fies_enable_field
   import fies_pkg::*;
#(
   parameter logic RESET_ON = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic wr,
   input wire logic [1:0] code,
   output logic [1:0] readback,
   output logic on
);

   typedef struct packed {
      logic on;
   } fies_field_t;

   fies_field_t st_r;
   fies_field_t st_nxt;

   // Only the two protected codes change state; 0h and 2h are ignored
   always_comb begin
      st_nxt = st_r;
      if (wr && code == `FIES_CODE_DIS) begin
         st_nxt.on = 1'b0;
      end else if (wr && code == `FIES_CODE_EN) begin
         st_nxt.on = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.on <= RESET_ON;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign on = st_r.on;
   assign readback = st_r.on ? `FIES_READ_EN : `FIES_READ_DIS;

endmodule : fies_enable_field

// ==== fies_fault_pair.sv ====
`timescale 1ns/1ps
`include "fies_params.svh"

// Latched fault bit cleared only by a paired status+clear write
module fies_fault_pair
   import fies_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic fault_in,
   input wire logic wr,
   input wire logic wr_status,
   input wire logic wr_clear,
   output logic flag
);

   typedef struct packed {
      logic flag;
      logic sync1;
      logic sync2;
      logic sync3;
   } fies_pair_t;

   fies_pair_t st_r;
   fies_pair_t st_nxt;

   // Fault arrives from analog monitors: three stages, agree on last two
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = fault_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      if (wr && wr_status && wr_clear) begin
         st_nxt.flag = 1'b0;
      end
      // Set beats clear so a fault in the clear cycle is kept
      if (st_r.sync2 && st_r.sync3) begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

endmodule : fies_fault_pair

// ==== fies_top.sv ====
`timescale 1ns/1ps
`include "fies_params.svh"

module fies_top
   import fies_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Fault sources, asynchronous levels
   input wire logic [7:0] supply_fault_in,
   input wire logic bus_timeout_in,
   input wire logic bad_string_cfg_in,
   input wire logic led_fault_in,
   // Interrupt pin, active high level
   output logic irq,
   // AXI4-Lite slave, write address channel
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Response codes; unmapped addresses are refused with a slave error
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Offsets are word indices and the byte address is four times the index,
   // so the two 16-bit registers never share a bus word
   // Byte address of a register index
   function automatic logic [11:0] fies_addr(input logic [7:0] idx);
      fies_addr = {2'h0, idx, 2'h0};
   endfunction : fies_addr

   // True when the address maps to a register
   function automatic logic fies_mapped(input logic [11:0] a);
      fies_mapped = (a == fies_addr(`FIES_IDX_ENABLES)) || (a == fies_addr(`FIES_IDX_SUPPLY)) ||
                    (a == fies_addr(`FIES_IDX_EVT_STATUS)) || (a == fies_addr(`FIES_IDX_EVT_CLEAR)) ||
                    (a == fies_addr(`FIES_IDX_EVT_ENABLE));
   endfunction : fies_mapped

   // State of the block outside the enable fields and fault pairs, registered by the single clocked process
   typedef struct packed {
      // Bus channel state and holding slots
      fies_wstate_t wst;
      fies_rstate_t rst;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      // Read answer, held while rvalid stands
      logic [31:0] rdata;
      logic [1:0] rresp;
      // Event registers and their source synchronisers
      logic [`FIES_N_EVT-1:0] evt_status;
      logic [`FIES_N_EVT-1:0] evt_enable;
      logic [`FIES_N_EVT-1:0] src_s1;
      logic [`FIES_N_EVT-1:0] src_s2;
      logic [`FIES_N_EVT-1:0] src_s3;
      // Registered pin
      logic irq;
   } fies_top_t;

   fies_top_t st_r;
   fies_top_t st_nxt;

   // Write decode
   logic wr_fire;
   logic [15:0] wdata16;
   logic lane_lo;
   logic lane_hi;
   logic en_wr;
   logic sup_wr;
   // Register contents and field states
   logic [7:0] en_rb;
   logic [3:0] en_on;
   logic [7:0] sup_flag;
   logic [15:0] enables_rd;
   logic [15:0] supply_rd;
   logic [`FIES_N_EVT-1:0] evt_raw;
   logic evt_en_wr;
   logic evt_clr_wr;
   logic [7:0] pair_wr;
   logic [3:0] irq_req;
   logic [31:0] rd_word;

   // A write commits in the cycle both address and data are held
   assign wr_fire = (st_r.wst == FIES_W_IDLE) && st_r.aw_got && st_r.w_got;
   assign wdata16 = st_r.wdata[15:0];
   assign lane_lo = st_r.wstrb[0];
   assign lane_hi = st_r.wstrb[1];
   assign en_wr = wr_fire && (st_r.awaddr == fies_addr(`FIES_IDX_ENABLES)) && lane_lo;
   assign sup_wr = wr_fire && (st_r.awaddr == fies_addr(`FIES_IDX_SUPPLY));
   // Event register strobes; both need the low byte lane
   assign evt_en_wr = wr_fire && lane_lo && (st_r.awaddr == fies_addr(`FIES_IDX_EVT_ENABLE));
   assign evt_clr_wr = wr_fire && lane_lo && (st_r.awaddr == fies_addr(`FIES_IDX_EVT_CLEAR));
   // Pairs 7..4 live in the upper byte lane, pairs 3..0 in the lower one
   assign pair_wr = {{4{sup_wr && lane_hi}}, {4{sup_wr && lane_lo}}};

   // Enable fields, all resetting to enabled; each moves only on code 1h or 3h,
   // so a stray all-zero write cannot silently mask the pin.
   // Order in the word, high to low: global, timeout, string, LED
   fies_enable_field #(.RESET_ON(1'b1)) u_global_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr(en_wr),
      .code(wdata16[`FIES_EN_GLOBAL_LO+1:`FIES_EN_GLOBAL_LO]),
      .readback(en_rb[7:6]),
      .on(en_on[3])
   );
   fies_enable_field #(.RESET_ON(1'b1)) u_timeout_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr(en_wr),
      .code(wdata16[`FIES_EN_TIMEOUT_LO+1:`FIES_EN_TIMEOUT_LO]),
      .readback(en_rb[5:4]),
      .on(en_on[2])
   );
   fies_enable_field #(.RESET_ON(1'b1)) u_bad_string_cfg_irq_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr(en_wr),
      .code(wdata16[`FIES_EN_STRING_LO+1:`FIES_EN_STRING_LO]),
      .readback(en_rb[3:2]),
      .on(en_on[1])
   );
   fies_enable_field #(.RESET_ON(1'b1)) u_led_fault_irq_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr(en_wr),
      .code(wdata16[`FIES_EN_LED_LO+1:`FIES_EN_LED_LO]),
      .readback(en_rb[1:0]),
      .on(en_on[0])
   );

   // Reserved upper byte reads zero
   assign enables_rd = {8'h00, en_rb};

   // Supply fault pairs: flag at odd bit 2k+1, acknowledge at 2k
   // Order k=7..0: checksum, sync clock loss, pump, pump capacitor,
   // input overcurrent, core undervoltage, input overvoltage, input undervoltage
   // Each pair writes only when its own byte lane is strobed
   genvar k;
   generate
      for (k = 0; k < `FIES_N_SUPPLY; k++) begin : g_pair
         fies_fault_pair u_pair (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .fault_in(supply_fault_in[k]),
            .wr(pair_wr[k]),
            .wr_status(wdata16[2*k+1]),
            .wr_clear(wdata16[2*k]),
            .flag(sup_flag[k])
         );
      end
   endgenerate

   // Acknowledge bits always read back zero; flags sit on odd bits,
   // so writing back a word just read can never clear a fault by accident
   always_comb begin
      supply_rd = `FIES_SUPPLY_RESET;
      for (int i = 0; i < `FIES_N_SUPPLY; i++) begin
         supply_rd[2*i+1] = sup_flag[i];
      end
   end

   // Word offered for the read address; the clear register is write-only and reads zero
   always_comb begin
      rd_word = 32'h00000000;
      if (s_axi_araddr == fies_addr(`FIES_IDX_ENABLES)) begin
         rd_word = {16'h0000, enables_rd};
      end else if (s_axi_araddr == fies_addr(`FIES_IDX_SUPPLY)) begin
         rd_word = {16'h0000, supply_rd};
      end else if (s_axi_araddr == fies_addr(`FIES_IDX_EVT_STATUS)) begin
         rd_word = {28'h0000000, st_r.evt_status};
      end else if (s_axi_araddr == fies_addr(`FIES_IDX_EVT_ENABLE)) begin
         rd_word = {28'h0000000, st_r.evt_enable};
      end
   end

   // LED-side events: 3 timeout, 2 bad string, 1 LED fault, 0 any supply flag;
   // bit 0 stays low here and is fed from the supply flags below
   assign evt_raw = {bus_timeout_in, bad_string_cfg_in, led_fault_in, 1'b0};

   // Pin requests before the global gate; supply flags feed the pin directly
   // so that a paired clear releases it at once while event enable bit 0 is clear
   assign irq_req[3] = |sup_flag;
   assign irq_req[2] = st_r.evt_status[3] && en_on[2];
   assign irq_req[1] = st_r.evt_status[2] && en_on[1];
   assign irq_req[0] = st_r.evt_status[1] && en_on[0];

   // Bus handshake, event logging and interrupt in one next-state block.
   // A write is held in the slots until both halves are in; it commits in the
   // idle cycle that follows and the response rises one edge later, so a read
   // issued after the response already sees the new contents. Both slots stay
   // full until the response is taken, which stops a second write from
   // overtaking the first.
   always_comb begin
      st_nxt = st_r;
      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end

      // Write channel: idle until both halves are held, then answer
      unique case (st_r.wst)
         FIES_W_IDLE: begin
            // Both halves in: commit this cycle, raise the response next
            if (st_r.aw_got && st_r.w_got) begin
               st_nxt.bresp = fies_mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
               st_nxt.wst = FIES_W_RESP;
            end
         end
         // Response stands until the master takes it
         FIES_W_RESP: begin
            if (s_axi_bready) begin
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got = 1'b0;
               st_nxt.wst = FIES_W_IDLE;
            end
         end
         // Spare state, never entered; falls back to idle
         FIES_W_HOLD: begin
            st_nxt.wst = FIES_W_IDLE;
         end
      endcase

      // Read returns a registered word one cycle after the address; the word is
      // captured at the accept edge, so a later write cannot change an answer
      unique case (st_r.rst)
         FIES_R_IDLE: begin
            if (s_axi_arvalid) begin
               st_nxt.rresp = fies_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
               st_nxt.rdata = rd_word;
               st_nxt.rst = FIES_R_DATA;
            end
         end
         FIES_R_DATA: begin
            if (s_axi_rready) begin
               st_nxt.rst = FIES_R_IDLE;
            end
         end
      endcase

      // Synchronise the LED-side sources; only the last two stages are used,
      // so a level caught mid-change by the first stage cannot reach a flag
      st_nxt.src_s1 = evt_raw;
      st_nxt.src_s2 = st_r.src_s1;
      st_nxt.src_s3 = st_r.src_s2;

      // Event enable and write-one-to-clear registers
      if (evt_en_wr) begin
         st_nxt.evt_enable = st_r.wdata[`FIES_N_EVT-1:0];
      end
      if (evt_clr_wr) begin
         st_nxt.evt_status = st_r.evt_status & ~st_r.wdata[`FIES_N_EVT-1:0];
      end

      // Sticky set applied last so it wins over a clear in the same cycle;
      // an event that lands on the clear edge is kept, never lost
      st_nxt.evt_status = st_nxt.evt_status | (st_r.src_s2 & st_r.src_s3);
      st_nxt.evt_status[0] = st_nxt.evt_status[0] | (|sup_flag);

      // Pin: global gate over the per-source requests and the event enables;
      // the per-source gates do not mask events routed through the event enables;
      // registered, so the pin follows its causes by one cycle
      st_nxt.irq = en_on[3] && ((|irq_req) || (|(st_r.evt_status & st_r.evt_enable)));
   end

   // Synchronous reset acts even while ce is low; otherwise a low ce freezes
   // every bit of state, a half-taken write included, until it rises again
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.wst <= FIES_W_IDLE;
         st_r.rst <= FIES_R_IDLE;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Ready only while the holding slot is empty, so each channel is taken once
   // Readies drop with ce, so nothing is taken while the state is frozen
   assign s_axi_awready = ce && !st_r.aw_got && st_r.wst == FIES_W_IDLE;
   assign s_axi_wready = ce && !st_r.w_got && st_r.wst == FIES_W_IDLE;
   assign s_axi_bvalid = st_r.wst == FIES_W_RESP;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = ce && st_r.rst == FIES_R_IDLE;
   assign s_axi_rvalid = st_r.rst == FIES_R_DATA;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign irq = st_r.irq;

endmodule : fies_top

// ==== fies_top_asserts.sv ====
`timescale 1ns/1ps
// Watches the register bus and the interrupt pin of the fault block
module fies_top_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   logic [11:0] ra_r;
   // Read data is judged by the address taken with it
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_en_code; s_axi_rvalid && ra_r == 12'h030 |-> (s_axi_rdata & 32'h55) == 32'h0; endproperty
   a_en_code: assert property (p_en_code) else $error("enable field odd");
   property p_rsv; s_axi_rvalid && ra_r == 12'h030 |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved byte set");
   // A latched fault or gate only drops after a write was answered
   property p_irq_fall; $fell(irq) |-> $past(s_axi_bvalid); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   property p_unm;
      s_axi_rvalid && !(ra_r inside {12'h030, 12'h038, 12'h080, 12'h084, 12'h088})
         |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not refused");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_ar_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_ar_lat: assert property (p_ar_lat) else $error("read answer late");
   property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
   c_irq_fall: cover property ($fell(irq));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
   c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : fies_top_asserts

// ==== fies_host.sv ====
`timescale 1ns/1ps
// Host processor model: bus master for the register bus
module fies_host (
   input wire logic aclk,
   output logic [11:0] s_axi_awaddr = 12'h0,
   output logic s_axi_awvalid = 1'b0,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata = 32'h0,
   output logic s_axi_wvalid = 1'b0,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready = 1'b0,
   output logic [11:0] s_axi_araddr = 12'h0,
   output logic s_axi_arvalid = 1'b0,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready = 1'b0
);
   logic slow = 1'b0;
   // Handshakes are sampled at the falling edge, where inputs are settled
   task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
      logic ha, hw, hb;
      int k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      do begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         k++;
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         s_axi_bready <= !hb && (!slow || k > 2);
      end while (!hb);
   endtask : wr
   // A slow host holds rready low a few cycles so the answer must stand
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr;
      int k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      do begin
         @(negedge aclk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         k++;
         if (ha) s_axi_arvalid <= 1'b0;
         s_axi_rready <= !hr && (!slow || k > 2);
      end while (!hr);
   endtask : rd
endmodule : fies_host

// ==== fies_top_tb.sv ====
`timescale 1ns/1ps
module fies_top_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [2:0] prot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [7:0] supply_fault_in = 8'h0;
   logic [2:0] ev = 3'h0;
   logic bus_timeout_in, bad_string_cfg_in, led_fault_in, irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] seed_r = 32'h9feb0a23;
   logic [3:0] en = 4'hf;
   int err_count = 0;
   int n_checks = 0;
   // LED-side fault sources as one vector: bit 0 LED, 1 string, 2 timeout
   assign {bus_timeout_in, bad_string_cfg_in, led_fault_in} = ev;
   fies_top dut (.aclk, .aresetn, .ce, .supply_fault_in, .bus_timeout_in, .bad_string_cfg_in, .led_fault_in, .irq,
      .s_axi_awaddr, .s_axi_awprot(prot), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fies_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   always #2 aclk = ~aclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // Enabled fields read 2h, disabled ones 0h
   function automatic logic [15:0] rb(input logic [3:0] e);
      logic [15:0] v = 16'h0;
      for (int f = 0; f < 4; f++) v[2*f+1] = e[f];
      return v;
   endfunction : rb
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
      u_host.rd(a, d, r);
      chk({r, d}, {er, 16'h0, e});
   endtask : rdc
   task automatic wrt(input logic [11:0] a, input logic [15:0] v);
      u_host.wr(a, v, r);
      chk({32'h0, r}, 34'h0);
   endtask : wrt
   // Pin is looked at on the falling edge, clear of the launching edge
   task automatic irqc(input logic e);
      @(negedge aclk);
      chk({33'h0, irq}, {33'h0, e});
   endtask : irqc
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt
   task automatic results;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   initial begin
      #20000;
      err_count++;
      results();
   end
   initial begin
      wt(10);
      aresetn <= 1'b1;
      rdc(12'h030, 16'h00aa, 2'b00);
      rdc(12'h038, 16'h0000, 2'b00);
      rdc(12'h03c, 16'h0000, 2'b10);
      // Random codes per field; odd codes act, 0h and 2h must be ignored
      for (int i = 0; i < 24; i++) begin
         seed_r = xs(seed_r);
         u_host.slow = seed_r[8];
         for (int f = 0; f < 4; f++) if (seed_r[2*f]) en[f] = seed_r[2*f+1];
         wrt(12'h030, {8'h0, seed_r[7:0]});
         rdc(12'h030, rb(en), 2'b00);
      end
      wrt(12'h030, 16'h00ff);
      // Each supply fault: latch, half writes ignored, paired write clears
      for (int i = 0; i < 8; i++) begin
         supply_fault_in <= 8'h1 << i;
         wt(6);
         supply_fault_in <= 8'h0;
         irqc(1'b1);
         rdc(12'h038, 16'h2 << (2 * i), 2'b00);
         wrt(12'h038, 16'h2 << (2 * i));
         wrt(12'h038, 16'h1 << (2 * i));
         rdc(12'h038, 16'h2 << (2 * i), 2'b00);
         irqc(1'b1);
         wrt(12'h038, 16'h3 << (2 * i));
         wt(2);
         irqc(1'b0);
         rdc(12'h038, 16'h0, 2'b00);
      end
      // Global gate masks a pending fault without losing it
      supply_fault_in <= 8'h01;
      wt(6);
      supply_fault_in <= 8'h0;
      wrt(12'h030, 16'h0040);
      irqc(1'b0);
      rdc(12'h030, 16'h002a, 2'b00);
      wrt(12'h030, 16'h00c0);
      irqc(1'b1);
      wrt(12'h038, 16'h0003);
      wt(2);
      irqc(1'b0);
      wrt(12'h084, 16'h000f);
      // LED-side sources: raise, mask by field, latch, enable, clear
      for (int j = 0; j < 3; j++) begin
         ev <= 3'h1 << j;
         wt(6);
         irqc(1'b1);
         wrt(12'h030, 16'h1 << (2 * j));
         wt(2);
         ev <= 3'h0;
         irqc(1'b0);
         rdc(12'h080, 16'h2 << j, 2'b00);
         wrt(12'h088, 16'h2 << j);
         wt(2);
         irqc(1'b1);
         wrt(12'h084, 16'h2 << j);
         wt(2);
         irqc(1'b0);
         wrt(12'h088, 16'h0);
      end
      results();
   end
endmodule : fies_top_tb
bind fies_top fies_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .irq(irq), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
